// ---- tap_boundary_scan_logic.sv ----
// Purpose: boundary-scan test logic with pad cells and pad mode control
// Assumes: tck is unrelated to core_clk; tms and tdi change away from tck
// Notes: pad controls are retimed into core_clk before reaching the pins
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// [R1] three-bit instruction shifter; updated value selects the test mode
// [R2] code 000 drives pads from the shifted and updated chain bits
// [R3] code 001 captures pad levels into the chain for shifting out
// [R4] code 101 puts every pad output into high impedance
// [R5] code 110 makes every pad drive a logic zero
// [R6] code 111 is bypass and is the instruction after power-up
// [R7] single-bit stage between tdi and tdo when the chain is not used
// [R8] full sixteen-state controller stepped by tms on tck edges
// [R9] one chain of cells over all pads, tdi in, tdo out
// [R10] chain also observes the output enables of the pads
// [R11] the tester feeds tck and tms to all parts and chains tdo to tdi
// [R12] codes 010, 011 and 100 behave as bypass, pads left normal
// [R13] instruction capture loads a pattern ending in binary 01
module tap_boundary_scan_logic
    import tap_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    input wire logic [NUM_PADS-1:0] core_out,
    input wire logic [NUM_PADS-1:0] core_oe,
    input wire logic [NUM_PADS-1:0] pad_in,
    output logic [NUM_PADS-1:0] pad_out,
    output logic [NUM_PADS-1:0] pad_oe
);
    tap_ctrl_if ctrl();

    tap_fsm u_fsm (
        .tck(tck),
        .arst_n(arst_n),
        .tms(tms),
        .ctrl(ctrl.fsm)
    );

    // pad and core levels seen from tck; none of them is in this domain
    logic [OBS_WIDTH-1:0] obs_raw;
    logic [OBS_WIDTH-1:0] obs_tck;
    logic [NUM_PADS-1:0] pad_in_t;
    logic [NUM_PADS-1:0] core_out_t;
    logic [NUM_PADS-1:0] core_oe_t;
    assign obs_raw = {core_oe, core_out, pad_in};
    assign pad_in_t = obs_tck[NUM_PADS-1:0];
    assign core_out_t = obs_tck[2*NUM_PADS-1:NUM_PADS];
    assign core_oe_t = obs_tck[3*NUM_PADS-1:2*NUM_PADS];

    sync2 #(
        .WIDTH(OBS_WIDTH)
    ) u_obs_sync (
        .clk(tck),
        .arst_n(arst_n),
        .async_in(obs_raw),
        .sync_out(obs_tck)
    );

    logic [IR_WIDTH-1:0] ir_shift;
    instr_t ir_value;
    instr_t next_ir;
    logic ir_load;
    logic ir_toggle;
    logic bypass_q;
    logic [CHAIN_LEN-1:0] chain;
    logic [CHAIN_LEN-1:0] upd;
    logic [CHAIN_LEN-1:0] capture_vec;
    logic upd_toggle;
    logic [NUM_PADS-1:0] upd_out_t;
    logic [NUM_PADS-1:0] upd_oe_t;
    logic bsr_sel;
    logic tdo_src;
    logic shifting;

    // per-pad cell layout: input, output data, output enable
    genvar i;
    generate
        for (i = 0; i < NUM_PADS; i++)
        begin : g_cell
            assign capture_vec[i*CELLS_PER_PAD+CELL_IN] = pad_in_t[i]; // [R3]
            assign capture_vec[i*CELLS_PER_PAD+CELL_OUT] = core_out_t[i];
            assign capture_vec[i*CELLS_PER_PAD+CELL_OE] = core_oe_t[i]; // [R10]
            assign upd_out_t[i] = upd[i*CELLS_PER_PAD+CELL_OUT];
            assign upd_oe_t[i] = upd[i*CELLS_PER_PAD+CELL_OE];
        end
    endgenerate

    // instruction shifter: capture pattern, then shift toward tdo
    always_ff @(posedge tck or negedge arst_n)
        if (!arst_n)
            ir_shift <= IR_CAPTURE;
        else if (ctrl.capture_ir)
            ir_shift <= IR_CAPTURE; // [R13]
        else if (ctrl.shift_ir)
            ir_shift <= {tdi, ir_shift[IR_WIDTH-1:1]}; // [R1]

    // active instruction; logic reset falls back to bypass
    assign ir_load = ctrl.update_ir
        | (ctrl.logic_reset & (ir_value != INSTR_BYPASS));
    assign next_ir = ctrl.logic_reset ? INSTR_BYPASS : instr_t'(ir_shift);

    // toggle tells the core domain a new word is held and stable
    always_ff @(posedge tck or negedge arst_n)
        if (!arst_n)
        begin
            ir_value <= INSTR_BYPASS; // [R6]
            ir_toggle <= 1'b0;
        end
        else if (ir_load)
        begin
            ir_value <= next_ir; // [R1]
            ir_toggle <= ~ir_toggle;
        end

    // the chain is used only by the two scan instructions
    assign bsr_sel = (ir_value == INSTR_EXTERNAL)
        | (ir_value == INSTR_SAMPLE); // [R12]

    // single-bit stage, captures zero as usual for bypass
    always_ff @(posedge tck or negedge arst_n)
        if (!arst_n)
            bypass_q <= 1'b0;
        else if (ctrl.capture_dr)
            bypass_q <= 1'b0;
        else if (ctrl.shift_dr)
            bypass_q <= tdi; // [R7]

    // boundary chain: parallel capture, serial shift from tdi
    always_ff @(posedge tck or negedge arst_n)
        if (!arst_n)
            chain <= '0;
        else if (ctrl.capture_dr && bsr_sel)
            chain <= capture_vec; // [R3]
        else if (ctrl.shift_dr && bsr_sel)
            chain <= {tdi, chain[CHAIN_LEN-1:1]}; // [R9]

    // update stage holds pad values while the chain shifts again
    always_ff @(posedge tck or negedge arst_n)
        if (!arst_n)
        begin
            upd <= '0;
            upd_toggle <= 1'b0;
        end
        else if (ctrl.update_dr && bsr_sel)
        begin
            upd <= chain; // [R2]
            upd_toggle <= ~upd_toggle;
        end

    // tdo source; chain end, bypass stage or instruction shifter
    assign shifting = ctrl.shift_ir | ctrl.shift_dr;
    assign tdo_src = ctrl.shift_ir ? ir_shift[0]
        : (bsr_sel ? chain[0] : bypass_q); // [R7]

    // tdo moves on the falling edge so the next part samples it cleanly
    always_ff @(negedge tck or negedge arst_n)
        if (!arst_n)
        begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end
        else
        begin
            tdo <= tdo_src; // [R9]
            tdo_oe <= shifting;
        end

    // core side: toggles cross by two flops, held words are then stable
    logic [1:0] tog_raw;
    logic [1:0] tog_core;
    logic [1:0] tog_seen;
    logic ir_new;
    logic upd_new;
    instr_t mode;
    logic [NUM_PADS-1:0] upd_out_c;
    logic [NUM_PADS-1:0] upd_oe_c;
    assign tog_raw = {upd_toggle, ir_toggle};
    assign ir_new = tog_core[0] ^ tog_seen[0];
    assign upd_new = tog_core[1] ^ tog_seen[1];

    sync2 #(
        .WIDTH(2)
    ) u_tog_sync (
        .clk(core_clk),
        .arst_n(arst_n),
        .async_in(tog_raw),
        .sync_out(tog_core)
    );

    // held words change only after a whole scan or a logic reset, far slower than core_clk
    always_ff @(posedge core_clk or negedge arst_n)
        if (!arst_n)
        begin
            tog_seen <= 2'h0;
            mode <= INSTR_BYPASS; // [R6]
            upd_out_c <= '0;
            upd_oe_c <= '0;
        end
        else
        begin
            tog_seen <= tog_core;
            if (ir_new)
                mode <= ir_value; // [R1]
            if (upd_new)
            begin
                upd_out_c <= upd_out_t;
                upd_oe_c <= upd_oe_t;
            end
        end

    // pad selection per mode; reserved codes keep normal pin behaviour
    logic mode_ext;
    logic mode_clamp;
    logic mode_hiz;
    logic [NUM_PADS-1:0] next_pad_out;
    logic [NUM_PADS-1:0] next_pad_oe;
    assign mode_ext = (mode == INSTR_EXTERNAL);
    assign mode_clamp = (mode == INSTR_CONTINUITY);
    assign mode_hiz = (mode == INSTR_TRISTATE);
    assign next_pad_out = mode_ext ? upd_out_c // [R2]
        : (mode_clamp ? '0 : core_out); // [R5]
    assign next_pad_oe = mode_ext ? upd_oe_c
        : (mode_clamp ? '1 // [R5]
        : (mode_hiz ? '0 : core_oe)); // [R4]

    // pads are registered so the pin drive never glitches
    always_ff @(posedge core_clk or negedge arst_n)
        if (!arst_n)
        begin
            pad_out <= '0;
            pad_oe <= '0;
        end
        else
        begin
            pad_out <= next_pad_out; // [R12]
            pad_oe <= next_pad_oe;
        end

    property p_ir_capture;
        @(posedge tck) disable iff (!arst_n)
        ctrl.capture_ir |=> (ir_shift[1:0] == 2'h1);
    endproperty
    a_ir_capture: assert property (p_ir_capture) // [R13]
        else $error("instruction capture pattern wrong");

    property p_ir_update;
        @(posedge tck) disable iff (!arst_n)
        ctrl.update_ir |=> (ir_value == $past(ir_shift));
    endproperty
    a_ir_update: assert property (p_ir_update) // [R1]
        else $error("update did not load the shifted instruction");

    property p_reset_bypass;
        @(posedge tck) disable iff (!arst_n)
        ctrl.logic_reset |=> (ir_value == INSTR_BYPASS);
    endproperty
    a_reset_bypass: assert property (p_reset_bypass) // [R6]
        else $error("logic reset did not select bypass");

    property p_bypass_stage;
        @(posedge tck) disable iff (!arst_n)
        ctrl.shift_dr && !bsr_sel ##1 ctrl.shift_dr
            |-> (tdo_src == $past(tdi));
    endproperty
    a_bypass_stage: assert property (p_bypass_stage) // [R7]
        else $error("bypass path is not one stage long");

    property p_chain_shift;
        @(posedge tck) disable iff (!arst_n)
        ctrl.shift_dr && bsr_sel |=> (chain[CHAIN_LEN-1] == $past(tdi));
    endproperty
    a_chain_shift: assert property (p_chain_shift) // [R9]
        else $error("chain did not take tdi");

    property p_sample_capture;
        @(posedge tck) disable iff (!arst_n)
        ctrl.capture_dr && bsr_sel
            |=> (chain[CELL_IN] == $past(pad_in_t[0]))
            && (chain[CELL_OE] == $past(core_oe_t[0]));
    endproperty
    a_sample_capture: assert property (p_sample_capture) // [R3] [R10]
        else $error("capture missed pad level or enable");

    property p_extest_drive;
        @(posedge core_clk) disable iff (!arst_n)
        mode_ext |=> (pad_out == $past(upd_out_c))
            && (pad_oe == $past(upd_oe_c));
    endproperty
    a_extest_drive: assert property (p_extest_drive) // [R2]
        else $error("external test did not drive updated values");

    property p_tristate;
        @(posedge core_clk) disable iff (!arst_n)
        mode_hiz |=> (pad_oe == '0);
    endproperty
    a_tristate: assert property (p_tristate) // [R4]
        else $error("pad still driven in tristate mode");

    property p_continuity;
        @(posedge core_clk) disable iff (!arst_n)
        mode_clamp |=> (pad_out == '0) && (pad_oe == '1);
    endproperty
    a_continuity: assert property (p_continuity) // [R5]
        else $error("pads not driving zero in continuity mode");

    property p_reserved;
        @(posedge core_clk) disable iff (!arst_n)
        (mode inside {INSTR_RSVD_A, INSTR_RSVD_B, INSTR_RSVD_C})
            |=> (pad_out == $past(core_out)) && (pad_oe == $past(core_oe));
    endproperty
    a_reserved: assert property (p_reserved) // [R12]
        else $error("reserved code disturbed normal pads");

    c_extest: cover property (@(posedge core_clk) disable iff (!arst_n)
        mode_ext && upd_new);
    c_sample: cover property (@(posedge tck) disable iff (!arst_n)
        ctrl.capture_dr && (ir_value == INSTR_SAMPLE));
    c_clamp: cover property (@(posedge core_clk) disable iff (!arst_n)
        mode_clamp);
    c_hiz: cover property (@(posedge core_clk) disable iff (!arst_n)
        mode_hiz);
endmodule : tap_boundary_scan_logic

`default_nettype wire

// ---- tap_pkg.sv ----
// Purpose: shared constants and types for the test access port block
// Assumes: pad count and cell layout are fixed for this device
// Notes: instruction codes are three bits, shifted least significant first
package tap_pkg;

    // pad and chain geometry
    localparam int NUM_PADS = 4;
    localparam int IR_WIDTH = 3;
    localparam int CELLS_PER_PAD = 3;
    localparam int CHAIN_LEN = NUM_PADS * CELLS_PER_PAD;
    localparam int OBS_WIDTH = CHAIN_LEN;

    // cell position inside one pad group of the chain
    localparam int CELL_IN = 0;
    localparam int CELL_OUT = 1;
    localparam int CELL_OE = 2;

    // fixed pattern loaded into the instruction shifter on capture
    localparam logic [IR_WIDTH-1:0] IR_CAPTURE = 3'h1;

    typedef enum logic [2:0] {
        INSTR_EXTERNAL = 3'h0,
        INSTR_SAMPLE = 3'h1,
        INSTR_RSVD_A = 3'h2,
        INSTR_RSVD_B = 3'h3,
        INSTR_RSVD_C = 3'h4,
        INSTR_TRISTATE = 3'h5,
        INSTR_CONTINUITY = 3'h6,
        INSTR_BYPASS = 3'h7
    } instr_t;

    typedef enum logic [3:0] {
        TAP_EXIT2_DR = 4'h0,
        TAP_EXIT1_DR = 4'h1,
        TAP_SHIFT_DR = 4'h2,
        TAP_PAUSE_DR = 4'h3,
        TAP_SELECT_IR = 4'h4,
        TAP_UPDATE_DR = 4'h5,
        TAP_CAPTURE_DR = 4'h6,
        TAP_SELECT_DR = 4'h7,
        TAP_EXIT2_IR = 4'h8,
        TAP_EXIT1_IR = 4'h9,
        TAP_SHIFT_IR = 4'ha,
        TAP_PAUSE_IR = 4'hb,
        TAP_IDLE = 4'hc,
        TAP_UPDATE_IR = 4'hd,
        TAP_CAPTURE_IR = 4'he,
        TAP_RESET = 4'hf
    } tap_state_t;

endpackage : tap_pkg

// ---- tap_ctrl_if.sv ----
// Purpose: strobes from the tap state machine to the scan registers
// Assumes: all signals live in the tck domain
// Notes: each strobe is high for the whole state it names
`timescale 1ns/1ps
`default_nettype none

interface tap_ctrl_if;
    logic logic_reset;
    logic capture_dr;
    logic shift_dr;
    logic update_dr;
    logic capture_ir;
    logic shift_ir;
    logic update_ir;

    modport fsm (
        output logic_reset, capture_dr, shift_dr, update_dr,
        output capture_ir, shift_ir, update_ir
    );
    modport user (
        input logic_reset, capture_dr, shift_dr, update_dr,
        input capture_ir, shift_ir, update_ir
    );
endinterface : tap_ctrl_if

`default_nettype wire

// ---- sync2.sv ----
// Purpose: two flip-flop synchroniser for levels
// Assumes: each bit is an independent level or a slow toggle
// Notes: the first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    // metastability settles in meta before anyone looks
    always_ff @(posedge clk or negedge arst_n)
        if (!arst_n)
        begin
            meta <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta <= async_in;
            sync_out <= meta;
        end
endmodule : sync2

`default_nettype wire

// ---- tap_fsm.sv ----
// Purpose: sixteen-state test access port controller
// Assumes: tms is stable around the rising edge of tck
// Notes: five tck edges with tms high always reach logic reset
`timescale 1ns/1ps
`default_nettype none

module tap_fsm
    import tap_pkg::*;
(
    input wire logic tck,
    input wire logic arst_n,
    input wire logic tms,
    tap_ctrl_if.fsm ctrl
);
    tap_state_t state;
    tap_state_t next_state;

    // state walk decoded from tms
    always_comb
    begin
        unique case (state) // [R8]
            TAP_RESET: next_state = tms ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: next_state = tms ? TAP_SELECT_DR : TAP_IDLE;
            TAP_SELECT_DR: next_state = tms ? TAP_SELECT_IR : TAP_CAPTURE_DR;
            TAP_CAPTURE_DR: next_state = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: next_state = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: next_state = tms ? TAP_UPDATE_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: next_state = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: next_state = tms ? TAP_UPDATE_DR : TAP_SHIFT_DR;
            TAP_UPDATE_DR: next_state = tms ? TAP_SELECT_DR : TAP_IDLE;
            TAP_SELECT_IR: next_state = tms ? TAP_RESET : TAP_CAPTURE_IR;
            TAP_CAPTURE_IR: next_state = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: next_state = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: next_state = tms ? TAP_UPDATE_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: next_state = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: next_state = tms ? TAP_UPDATE_IR : TAP_SHIFT_IR;
            TAP_UPDATE_IR: next_state = tms ? TAP_SELECT_DR : TAP_IDLE;
        endcase
    end

    // state register, parked in logic reset at power-up
    always_ff @(posedge tck or negedge arst_n)
        if (!arst_n)
            state <= TAP_RESET;
        else
            state <= next_state;

    // strobes are plain state decodes
    assign ctrl.logic_reset = (state == TAP_RESET);
    assign ctrl.capture_dr = (state == TAP_CAPTURE_DR);
    assign ctrl.shift_dr = (state == TAP_SHIFT_DR);
    assign ctrl.update_dr = (state == TAP_UPDATE_DR);
    assign ctrl.capture_ir = (state == TAP_CAPTURE_IR);
    assign ctrl.shift_ir = (state == TAP_SHIFT_IR);
    assign ctrl.update_ir = (state == TAP_UPDATE_IR);

    property p_tms_reset;
        @(posedge tck) disable iff (!arst_n)
        tms [*5] |=> (state == TAP_RESET);
    endproperty
    a_tms_reset: assert property (p_tms_reset) // [R8]
        else $error("five tms highs did not reach logic reset");

    property p_ir_path;
        @(posedge tck) disable iff (!arst_n)
        (state == TAP_SELECT_IR) && !tms ##1 !tms
            |=> (state == TAP_SHIFT_IR);
    endproperty
    a_ir_path: assert property (p_ir_path) // [R8]
        else $error("select ir, 0, 0 did not land in shift ir");
endmodule : tap_fsm

`default_nettype wire

// ---- tap_partner.sv ----
// Purpose: tester model on the far side of the scan port
// Assumes: the block's state machine starts in logic reset or idle
// Notes: tck stands low between frames; tms and tdi rest at pull-up level
`timescale 1ns/1ps
`default_nettype none

module tap_partner (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    logic seen_oe;

    // idle lines sit at the pull-up level
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // one tck period; tdo is taken while stable, just before the rise
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #3;
        q = tdo;
        seen_oe = tdo_oe;
        tck = 1'b1;
        #3;
        tck = 1'b0;
    endtask : step

    // five tms-high edges then park in idle
    task automatic tap_reset();
        logic q;
        #1.3;
        repeat (5) step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
        tms = 1'b1;
    endtask : tap_reset

    // full scan from idle back to idle, lsb first, returns shifted-out bits
    task automatic scan(input logic ir, input logic [11:0] din, input int n,
                        output logic [11:0] dout, output logic oe_ok);
        logic q;
        dout = '0;
        oe_ok = 1'b1;
        #1.3; // offset keeps tck unrelated to core_clk
        step(1'b1, 1'b1, q);
        if (ir)
            step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
        step(1'b0, 1'b1, q);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
            oe_ok &= seen_oe;
        end
        step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
        tdi = 1'b1;
        tms = 1'b1;
    endtask : scan
endmodule : tap_partner

`default_nettype wire

// ---- testbench.sv ----
// Purpose: self-checking bench for the boundary-scan block
// Assumes: tester model steps tck only inside frames
// Notes: pad results are checked after the core-side retiming settles
`timescale 1ns/1ps
`default_nettype none

module testbench
    import tap_pkg::*;
;
    logic core_clk;
    logic arst_n;
    wire logic tck;
    wire logic tms;
    wire logic tdi;
    wire logic tdo;
    wire logic tdo_oe;
    logic [NUM_PADS-1:0] core_out;
    logic [NUM_PADS-1:0] core_oe;
    logic [NUM_PADS-1:0] pad_in;
    wire logic [NUM_PADS-1:0] pad_out;
    wire logic [NUM_PADS-1:0] pad_oe;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    int seed;
    logic [31:0] r;
    logic [11:0] q;
    logic ok;

    // core clock, 20 ns
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    tap_boundary_scan_logic DUT (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .tck(tck),
        .tms(tms),
        .tdi(tdi),
        .tdo(tdo),
        .tdo_oe(tdo_oe),
        .core_out(core_out),
        .core_oe(core_oe),
        .pad_in(pad_in),
        .pad_out(pad_out),
        .pad_oe(pad_oe)
    );

    tap_partner tester (
        .tck(tck),
        .tms(tms),
        .tdi(tdi),
        .tdo(tdo),
        .tdo_oe(tdo_oe)
    );

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test

    // chain image after capture: pin, core data, core enable per pad
    function automatic logic [11:0] cap_exp(input logic [3:0] pin,
                                            input logic [3:0] co,
                                            input logic [3:0] ce);
        logic [11:0] v;
        for (int i = 0; i < NUM_PADS; i++)
        begin
            v[CELLS_PER_PAD * i + CELL_IN] = pin[i];
            v[CELLS_PER_PAD * i + CELL_OUT] = co[i];
            v[CELLS_PER_PAD * i + CELL_OE] = ce[i];
        end
        return v;
    endfunction : cap_exp

    // expected {pad_out, pad_oe} for an instruction
    function automatic logic [7:0] pad_exp(input logic [2:0] code,
                                           input logic [11:0] upd,
                                           input logic [3:0] co,
                                           input logic [3:0] ce);
        logic [7:0] v;
        v = {co, ce};
        for (int i = 0; i < NUM_PADS; i++)
            if (code == 3'h0)
                {v[4 + i], v[i]} = {upd[3 * i + 1], upd[3 * i + 2]};
        if (code == 3'h5)
            v[3:0] = 4'h0;
        if (code == 3'h6)
            v = 8'h0f;
        return v;
    endfunction : pad_exp

    // load an instruction, scan the selected data path, check the pads
    task automatic run_case(input logic [2:0] code);
        logic [11:0] d;
        int n;
        @(negedge core_clk);
        r = $random(seed);
        {core_out, core_oe, pad_in} = r[11:0];
        tester.scan(1'b1, {9'h000, code}, IR_WIDTH, q, ok);
        check(q, 12'h001);
        check(ok, 1'b1);
        r = $random(seed);
        d = r[11:0];
        n = (code <= 3'h1) ? CHAIN_LEN : 4;
        tester.scan(1'b0, d, n, q, ok);
        if (n == CHAIN_LEN)
            check(q, cap_exp(pad_in, core_out, core_oe));
        else
            check(q, {8'h00, d[2:0], 1'b0});
        repeat (10) @(negedge core_clk);
        check({pad_out, pad_oe}, pad_exp(code, d, core_out, core_oe));
        check(tdo_oe, 1'b0);
        $display("case with code %0d done", code);
    endtask : run_case

    // bounded run time
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            end_of_test();
        end
    end

    // main sequence: power-up, every code, random codes, tms reset
    initial
    begin
        seed = 32'h1cba;
        arst_n = 1'b0;
        core_out = 4'h0;
        core_oe = 4'h0;
        pad_in = 4'h0;
        repeat (16) @(negedge core_clk);
        arst_n = 1'b1;
        core_out = 4'ha;
        core_oe = 4'h6;
        repeat (3) @(negedge core_clk);
        check({pad_out, pad_oe}, 8'ha6);
        tester.tap_reset();
        tester.scan(1'b0, 12'h00b, 4, q, ok);
        check(q, 12'h006);
        $display("power-up bypass test done");
        for (int c = 0; c < 8; c++)
            run_case(c[2:0]);
        repeat (8)
        begin
            r = $random(seed);
            run_case(r[2:0]);
        end
        run_case(3'h6);
        tester.tap_reset();
        repeat (10) @(negedge core_clk);
        check({pad_out, pad_oe}, {core_out, core_oe});
        $display("tms reset test done");
        // mid-run reset from tristate; pads and tap must fall back at once
        run_case(3'h5);
        arst_n = 1'b0;
        repeat (4) @(negedge core_clk);
        check({pad_out, pad_oe, tdo, tdo_oe}, 10'h000);
        arst_n = 1'b1;
        repeat (3) @(negedge core_clk);
        check({pad_out, pad_oe}, {core_out, core_oe});
        tester.tap_reset();
        tester.scan(1'b0, 12'h005, 4, q, ok);
        check(q, 12'h00a);
        $display("mid-run reset test done");
        end_of_test();
    end
endmodule : testbench

`default_nettype wire
